// ==== dv/sac_pipe_model.sv ====
`timescale 1ns/1ps
// Pipeline side: issues virtual references, back to back when called so
module sac_pipe_model (
  input  wire logic   clk_i,
  output logic        ref_valid_o,
  output logic [31:0] ref_vaddr_o,
  output logic [1:0]  ref_priv_o,
  output logic        err_level_o
);
  initial
  begin
    ref_valid_o = 1'b0;
    ref_vaddr_o = 32'h0;
    ref_priv_o  = 2'h0;
    err_level_o = 1'b0;
  end
  // One reference, launched just after the edge and held until the next issue or stop
  task automatic issue(input logic [31:0] va, input logic [1:0] pr, input logic el);
    @(posedge clk_i);
    ref_valid_o <= 1'b1;
    ref_vaddr_o <= va;
    ref_priv_o  <= pr;
    err_level_o <= el;
  endtask
  // Idle: the address turns over so a stale value is never taken for a live one
  task automatic stop();
    @(posedge clk_i);
    ref_valid_o <= 1'b0;
    ref_vaddr_o <= ~ref_vaddr_o;
  endtask
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
// Self-checking bench for the segment access control block
module testbench;
  localparam logic [7:0]  CC_SUP = 8'h0f;
  // Outcome per mode, two bits each (0 error, 1 mapped, 2 unmapped), mode 7 leftmost
  localparam logic [15:0] KERN_T = 16'h8a56;
  localparam logic [15:0] SUPV_T = 16'h8950;
  localparam logic [15:0] USER_T = 16'h8140;
  localparam logic [31:0] EDGES [12] = '{32'he000_0000, 32'hdfff_ffff, 32'hc000_0000,
    32'hbfff_ffff, 32'ha000_0000, 32'h9fff_ffff, 32'h8000_0000, 32'h7fff_ffff,
    32'h4000_0000, 32'h3fff_ffff, 32'h0000_0000, 32'hffff_ffff};
  logic        sys_clk_i   = 1'b0;
  logic        srst_i      = 1'b1;
  logic        reg_wr_i    = 1'b0;
  logic [2:0]  reg_sel_i   = 3'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        mc_event_i  = 1'b0;
  logic [4:0]  mc_code_i   = 5'h00;
  logic        mc_clear_i  = 1'b0;
  logic        ref_valid_i, error_level_flag_i, res_valid_o, res_addr_err_o, res_mapped_o;
  logic [31:0] ref_vaddr_i, reg_rdata_o, walk_table_base_o, walk_m, va, pr;
  logic [31:0] seed = 32'hf477e2ca;
  logic [1:0]  ref_priv_i;
  logic [4:0]  machine_check_cause_o, cause_m;
  logic [35:0] res_paddr_o;
  logic [2:0]  res_cca_o, res_seg_o;
  logic [15:0] cfg_m [6];
  logic [44:0] exp_q [$];
  logic [44:0] e;
  wire  [1:0]  act_s = {res_addr_err_o, res_mapped_o};
  int          fails = 0;
  int          checks_done = 0;
  int          cyc = 0;

  always #25 sys_clk_i = ~sys_clk_i;

  sac_top #(.CC_SUPPORTED(CC_SUP)) dut_u (
    .sys_clk_i, .srst_i, .reg_wr_i, .reg_sel_i, .reg_wdata_i, .reg_rdata_o,
    .mc_event_i, .mc_code_i, .mc_clear_i, .machine_check_cause_o,
    .ref_valid_i, .ref_vaddr_i, .ref_priv_i, .error_level_flag_i,
    .res_valid_o, .res_addr_err_o, .res_mapped_o, .res_paddr_o, .res_cca_o,
    .res_seg_o, .walk_table_base_o
  );
  sac_pipe_model pipe_u (
    .clk_i(sys_clk_i), .ref_valid_o(ref_valid_i), .ref_vaddr_o(ref_vaddr_i),
    .ref_priv_o(ref_priv_i), .err_level_o(error_level_flag_i)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    checks_done++;
    if (seen !== want)
    begin
      fails++;
      $display("unexpected at %0t: seen %h, expected %h", $time, seen, want);
    end
  endtask

  task automatic wrap_up();
    if (fails == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Expected result: {unmapped, cca, error, mapped, segment, paddr}
  function automatic logic [44:0] ref_exp(input logic [31:0] v, input logic [1:0] p,
                                          input logic el);
    logic [2:0]  t, sg, cc;
    logic [15:0] c, tb;
    logic [1:0]  a;
    t  = v[31:29];
    sg = (t > 3'h3) ? 3'h7 - t : ((t > 3'h1) ? 3'h4 : 3'h5);
    c  = cfg_m[sg];
    tb = (p == 2'h0) ? KERN_T : ((p == 2'h1) ? SUPV_T : USER_T);
    a  = tb[c[6:4]*2 +: 2];
    cc = c[2:0];
    if (c[3] && el)
    begin
      a  = 2'h2;
      cc = sac_pkg::CC_UNCACHED;
    end
    return {a == 2'h2, cc, a == 2'h0, a == 2'h1, sg, (a == 2'h2) ? {c[15:9], v[28:0]} : 36'h0};
  endfunction

  task automatic wr_reg(input logic [2:0] s, input logic [31:0] d);
    logic [15:0] w;
    int          k;
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b1;
    reg_sel_i   <= s;
    reg_wdata_i <= d;
    if (s == sac_pkg::SEL_WALK)
      walk_m = d;
    for (int h = 0; h < 2; h++)
    begin
      k = (int'(s) - 2) * 2 + h;
      w = d[h*16 +: 16];
      if (k >= 0 && k < 6)
        cfg_m[k] = (w & sac_pkg::CFG_WMASK) | (CC_SUP[w[2:0]] ? w[2:0] : cfg_m[k][2:0]);
    end
  endtask

  task automatic rd_reg(input logic [2:0] s);
    logic [31:0] want;
    @(posedge sys_clk_i);
    reg_wr_i  <= 1'b0;
    reg_sel_i <= s;
    case (s)
      sac_pkg::SEL_CFG_LOW:  want = {cfg_m[1], cfg_m[0]};
      sac_pkg::SEL_CFG_MID:  want = {cfg_m[3], cfg_m[2]};
      sac_pkg::SEL_CFG_HIGH: want = {cfg_m[5], cfg_m[4]};
      sac_pkg::SEL_WALK:     want = walk_m;
      default:               want = 32'h0;
    endcase
    @(negedge sys_clk_i);
    check(reg_rdata_o, want);
    check(walk_table_base_o, walk_m);
  endtask

  // Driver notes the expectation, then hands the reference to the pipeline
  task automatic send(input logic [31:0] v, input logic [1:0] p, input logic el);
    exp_q.push_back(ref_exp(v, p, el));
    pipe_u.issue(v, p, el);
  endtask

  // Each result is matched against the oldest expectation; a spare result sees x
  always @(negedge sys_clk_i)
    if (res_valid_o === 1'b1)
    begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      check(act_s, e[40:39]);
      check(res_seg_o, e[38:36]);
      check(res_paddr_o, e[35:0]);
      if (e[44] !== 1'b0)
        check(res_cca_o, e[43:41]);
    end

  // Cut a hang short; the run needs under two thousand cycles
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      wrap_up();
    end
  end

  initial
  begin
    cfg_m = '{sac_pkg::CFG0_RST, sac_pkg::CFG1_RST, sac_pkg::CFG2_RST,
              sac_pkg::CFG3_RST, sac_pkg::CFG4_RST, sac_pkg::CFG5_RST};
    walk_m = 32'h0;
    repeat (12) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    // Reset contents, including the unmapped selects
    for (int s = 0; s < 8; s++)
      rd_reg(3'(s));
    // Every segment boundary at each privilege, with and without error level
    foreach (EDGES[i])
      for (int p = 0; p < 6; p++)
        send(EDGES[i], 2'(p % 3), p > 2);
    pipe_u.stop();
    // Random configurations, each pass forcing one mode, then random references
    for (int i = 0; i < 24; i++)
    begin
      va = rnd();
      va[6:4] = 3'(i);
      wr_reg(sac_pkg::SEL_CFG_LOW, va);
      wr_reg(sac_pkg::SEL_CFG_MID, rnd());
      wr_reg(sac_pkg::SEL_CFG_HIGH, rnd());
      wr_reg(sac_pkg::SEL_WALK, rnd());
      // reads let new settings settle before any reference uses them
      for (int s = 1; s < 7; s++)
        rd_reg(3'(s));
      repeat (16)
      begin
        va = rnd();
        pr = rnd();
        send(va, 2'(pr % 3), pr[8]);
      end
      pipe_u.stop();
    end
    // Every cause code; a clear collides with code 5 and clears between codes
    for (int c = 0; c < 32; c++)
    begin
      @(posedge sys_clk_i);
      mc_event_i <= 1'b1;
      mc_code_i  <= 5'(c);
      mc_clear_i <= (c == 5);
      cause_m = (c < 7 || c > 23) ? 5'(c) : 5'h00;
      @(posedge sys_clk_i);
      mc_event_i <= 1'b0;
      mc_clear_i <= 1'b1;
      @(negedge sys_clk_i);
      check(machine_check_cause_o, cause_m);
    end
    repeat (3) @(posedge sys_clk_i);
    check(exp_q.size(), 0);
    wrap_up();
  end
endmodule

// ==== rtl/sac_mode_dec.sv ====
`timescale 1ns/1ps
// Access mode decode for one privilege level and one mode
module sac_mode_dec (
  input  wire logic [2:0]         mode_i,
  input  wire sac_pkg::sac_priv_e priv_i,
  output sac_pkg::sac_act_e       act_o
);
  wire is_k = (priv_i == sac_pkg::PRIV_KERNEL);
  wire is_s = (priv_i == sac_pkg::PRIV_SUPER);
  sac_pkg::sac_act_e act_k;

  // Mode table; unknown privilege code treated as the least privileged
  always_comb
  begin
    act_k = sac_pkg::ACT_ERROR;
    case (mode_i)
      3'h0: act_k = is_k ? sac_pkg::ACT_UNMAPPED : sac_pkg::ACT_ERROR;
      3'h1: act_k = is_k ? sac_pkg::ACT_MAPPED : sac_pkg::ACT_ERROR;
      3'h2: act_k = (is_k || is_s) ? sac_pkg::ACT_MAPPED : sac_pkg::ACT_ERROR;
      3'h3: act_k = sac_pkg::ACT_MAPPED;
      3'h4: act_k = is_k ? sac_pkg::ACT_UNMAPPED : sac_pkg::ACT_MAPPED;
      3'h5: act_k = (is_k || is_s) ? sac_pkg::ACT_UNMAPPED : sac_pkg::ACT_ERROR;
      3'h6: act_k = sac_pkg::ACT_ERROR;
      3'h7: act_k = sac_pkg::ACT_UNMAPPED;
      default: act_k = sac_pkg::ACT_ERROR;
    endcase
  end

  assign act_o = act_k;
endmodule

// ==== rtl/sac_pkg.sv ====
// Function
// - Three 32-bit registers each hold two configurations, odd one upper, even lower.
// - Bits 15:9 of a configuration give physical high bits when unmapped.
// - Bits 6:4 select mapped, unmapped or error per privilege level.
// - Error-unmap bit at error level makes segment unmapped and uncached.
// - Bits 2:0 give the coherency attribute used when unmapped.
// - Writes of unsupported coherency values leave the field unchanged.
// - Mode 000 errors user and supervisor, kernel unmapped.
// - Mode 001 errors user and supervisor, kernel mapped.
// - Mode 010 errors user, supervisor and kernel mapped.
// - Mode 011 maps every privilege level.
// - Mode 100 maps user and supervisor, kernel unmapped.
// - Mode 101 errors user, supervisor and kernel unmapped.
// - Mode 111 leaves every privilege level unmapped.
// - Configuration 0 covers 0xe0000000 up, configuration 1 covers 0xc0000000 up.
// - Configuration 2 covers 0xa0000000 up, configuration 3 covers 0x80000000 up.
// - Configuration 4 covers 0x40000000 up, configuration 5 covers 0x00000000 up.
// - Reset values follow the legacy fixed segmentation layout.
// - Walk table base register is 32-bit read/write, reset zero.
// - Cause 0 none, 1 multiple hit, 2 speculative multiple hit.
// - Cause 3 bad fixed-page size, 4 fixed-page set mismatch.
// - Cause 5 dual-page second entry invalid, 6 huge page; 24-31 implementation.
package sac_pkg;
  // Register selects on the coprocessor port
  localparam logic [2:0] SEL_CFG_LOW  = 3'h2;
  localparam logic [2:0] SEL_CFG_MID  = 3'h3;
  localparam logic [2:0] SEL_CFG_HIGH = 3'h4;
  localparam logic [2:0] SEL_WALK     = 3'h5;
  // Configuration field positions
  localparam int PA_LSB = 9;
  localparam int PA_MSB = 15;
  localparam int AM_LSB = 4;
  localparam int AM_MSB = 6;
  localparam int UNMAP_EN_BIT = 3;
  localparam int CC_LSB = 0;
  localparam int CC_MSB = 2;
  // Bits of a configuration stored straight from a write; coherency bits 2:0 are stored apart (bits 8:7 reserved, read zero)
  localparam logic [15:0] CFG_WMASK = 16'hfe78;
  localparam logic [2:0]  CC_UNCACHED = 3'h2;
  // Reset values, one per configuration
  localparam logic [15:0] CFG0_RST = 16'h0010;
  localparam logic [15:0] CFG1_RST = 16'h0020;
  localparam logic [15:0] CFG2_RST = 16'h0002;
  localparam logic [15:0] CFG3_RST = 16'h0003;
  localparam logic [15:0] CFG4_RST = 16'h0438;
  localparam logic [15:0] CFG5_RST = 16'h0038;
  localparam logic [31:0] WALK_RST = 32'h0000_0000;
  // Machine-check cause codes
  localparam logic [4:0] MC_NONE      = 5'h00;
  localparam logic [4:0] MC_MULTI     = 5'h01;
  localparam logic [4:0] MC_MULTI_SPEC = 5'h02;
  localparam logic [4:0] MC_FIX_SIZE  = 5'h03;
  localparam logic [4:0] MC_FIX_SET   = 5'h04;
  localparam logic [4:0] MC_DUAL_PTE  = 5'h05;
  localparam logic [4:0] MC_HUGE_PG   = 5'h06;
  localparam logic [4:0] MC_IMPL_LO   = 5'h18;
  // Privilege levels
  typedef enum logic [1:0] {PRIV_KERNEL, PRIV_SUPER, PRIV_USER} sac_priv_e;
  // Outcome of a reference
  typedef enum logic [1:0] {ACT_ERROR, ACT_MAPPED, ACT_UNMAPPED} sac_act_e;
endpackage

// ==== rtl/sac_seg_if.sv ====
`timescale 1ns/1ps
// Carries one configuration from the register file to a decoder
interface sac_seg_if;
  logic [15:0] cfg;
  modport src (output cfg);
  modport dst (input cfg);
endinterface

// ==== rtl/sac_top.sv ====
`timescale 1ns/1ps
// Segment access control: configuration registers and reference classifier
module sac_top #(
  parameter logic [7:0] CC_SUPPORTED = 8'h0f // Coherency values accepted on write
) (
  input  wire logic                sys_clk_i,
  input  wire logic                srst_i,
  // Coprocessor register port
  input  wire logic                reg_wr_i,
  input  wire logic [2:0]          reg_sel_i,
  input  wire logic [31:0]         reg_wdata_i,
  output logic [31:0]              reg_rdata_o,
  // Machine-check report from the translation logic
  input  wire logic                mc_event_i,
  input  wire logic [4:0]          mc_code_i,
  input  wire logic                mc_clear_i,
  output logic [4:0]               machine_check_cause_o,
  // Pipeline reference
  input  wire logic                ref_valid_i,
  input  wire logic [31:0]         ref_vaddr_i,
  input  wire logic [1:0]          ref_priv_i,
  input  wire logic                error_level_flag_i,
  output logic                     res_valid_o,
  output logic                     res_addr_err_o,
  output logic                     res_mapped_o,
  output logic [35:0]              res_paddr_o,
  output logic [2:0]               res_cca_o,
  output logic [2:0]               res_seg_o,
  output logic [31:0]              walk_table_base_o
);
  // Elaboration refuses a mask that would freeze every coherency write
  if (CC_SUPPORTED == 8'h00)
  begin : g_cc_check
    $error("CC_SUPPORTED must accept at least one value");
  end

  // Assertions share the core clock; all but the three reset checks stay quiet while reset is held
  default clocking sac_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  logic [15:0] cfg_q [6];
  logic [15:0] cfg_d [6];
  logic [31:0] walk_table_base_q;
  logic [4:0]  mc_cause_q;
  logic        res_valid_q;
  logic        res_err_q;
  logic        res_map_q;
  logic [35:0] res_paddr_q;
  logic [2:0]  res_cca_q;
  logic [2:0]  res_seg_q;

  // Which pair a write targets
  wire [2:0] wr_pair;
  assign wr_pair[0] = reg_wr_i && (reg_sel_i == sac_pkg::SEL_CFG_LOW);
  assign wr_pair[1] = reg_wr_i && (reg_sel_i == sac_pkg::SEL_CFG_MID);
  assign wr_pair[2] = reg_wr_i && (reg_sel_i == sac_pkg::SEL_CFG_HIGH);
  wire   wr_walk    = reg_wr_i && (reg_sel_i == sac_pkg::SEL_WALK);

  // Next value of each configuration; odd index takes upper half
  always_comb
  begin
    logic [15:0] half;
    logic [2:0]  cc_new;
    half   = 16'h0000;
    cc_new = 3'h0;
    for (int i = 0; i < 6; i++)
    begin
      cfg_d[i] = cfg_q[i];
      half     = (i % 2 == 1) ? reg_wdata_i[31:16] : reg_wdata_i[15:0];
      cc_new   = half[sac_pkg::CC_MSB:sac_pkg::CC_LSB];
      if (wr_pair[i/2])
      begin
        // physical field and mode field stored, reserved bits zero
        cfg_d[i] = half & sac_pkg::CFG_WMASK;
        cfg_d[i][sac_pkg::CC_MSB:sac_pkg::CC_LSB] =
          CC_SUPPORTED[cc_new] ? cc_new : cfg_q[i][sac_pkg::CC_MSB:sac_pkg::CC_LSB];
      end
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      cfg_q[0] <= sac_pkg::CFG0_RST;
      cfg_q[1] <= sac_pkg::CFG1_RST;
      cfg_q[2] <= sac_pkg::CFG2_RST;
      cfg_q[3] <= sac_pkg::CFG3_RST;
      cfg_q[4] <= sac_pkg::CFG4_RST;
      cfg_q[5] <= sac_pkg::CFG5_RST;
    end
    else
    begin
      for (int i = 0; i < 6; i++)
        cfg_q[i] <= cfg_d[i];
    end
  end

  // Walk base register
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      walk_table_base_q <= sac_pkg::WALK_RST;
    else if (wr_walk)
      walk_table_base_q <= reg_wdata_i;
  end

  // Cause is captured on every documented event and held until cleared; a new event beats the clear
  wire mc_code_ok = (mc_code_i <= sac_pkg::MC_HUGE_PG) || (mc_code_i >= sac_pkg::MC_IMPL_LO);
  always_ff @(posedge sys_clk_i)
  begin
    // only documented codes reach the field
    if (srst_i)
      mc_cause_q <= sac_pkg::MC_NONE;
    else if (mc_event_i && mc_code_ok)
      mc_cause_q <= mc_code_i;
    else if (mc_clear_i)
      mc_cause_q <= sac_pkg::MC_NONE;
  end

  // Read mux; pairs are rebuilt from the configurations
  wire [31:0] rd_low  = {cfg_q[1], cfg_q[0]};
  wire [31:0] rd_mid  = {cfg_q[3], cfg_q[2]};
  wire [31:0] rd_high = {cfg_q[5], cfg_q[4]};
  always_comb
  begin
    case (reg_sel_i)
      sac_pkg::SEL_CFG_LOW:  reg_rdata_o = rd_low;
      sac_pkg::SEL_CFG_MID:  reg_rdata_o = rd_mid;
      sac_pkg::SEL_CFG_HIGH: reg_rdata_o = rd_high;
      sac_pkg::SEL_WALK:     reg_rdata_o = walk_table_base_q;
      default:               reg_rdata_o = 32'h0000_0000;
    endcase
  end

  // Segment selection by top address bits
  wire [2:0] top3 = ref_vaddr_i[31:29];
  logic [2:0] seg_idx;
  always_comb
  begin
    case (top3)
      3'h7: seg_idx = 3'h0;
      3'h6: seg_idx = 3'h1;
      // the two 512 MB windows below
      3'h5: seg_idx = 3'h2;
      3'h4: seg_idx = 3'h3;
      // two 512 MB windows forming the upper 1 GB half of the lower space
      3'h3: seg_idx = 3'h4;
      3'h2: seg_idx = 3'h4;
      default: seg_idx = 3'h5;
    endcase
  end

  // Hand the chosen configuration to the decoder through the carrier
  sac_seg_if seg_bus ();
  assign seg_bus.cfg = cfg_q[seg_idx];

  wire [15:0] sel_cfg = seg_bus.cfg;
  wire [2:0]  sel_am  = sel_cfg[sac_pkg::AM_MSB:sac_pkg::AM_LSB];
  wire        sel_unmap_en = sel_cfg[sac_pkg::UNMAP_EN_BIT];
  wire [6:0]  sel_pa  = sel_cfg[sac_pkg::PA_MSB:sac_pkg::PA_LSB];
  wire sac_pkg::sac_priv_e priv = sac_pkg::sac_priv_e'(ref_priv_i);
  sac_pkg::sac_act_e mode_act;

  sac_mode_dec u_dec (
    .mode_i (sel_am),
    .priv_i (priv),
    .act_o  (mode_act)
  );

  // error level overrides the mode when enabled
  wire err_unmap = sel_unmap_en && error_level_flag_i;
  wire fin_err = !err_unmap && (mode_act == sac_pkg::ACT_ERROR);
  wire fin_map = !err_unmap && (mode_act == sac_pkg::ACT_MAPPED);
  // coherency from the configuration, uncached at error level when the unmap bit is set
  wire [2:0] fin_cca = err_unmap ? sac_pkg::CC_UNCACHED
                              : sel_cfg[sac_pkg::CC_MSB:sac_pkg::CC_LSB];
  // unmapped physical address replaces top bits; low 29 bits pass through
  wire [35:0] fin_pa = {sel_pa, ref_vaddr_i[28:0]};

  // Result registered one cycle after the reference
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      res_valid_q <= 1'b0;
      res_err_q   <= 1'b0;
      res_map_q   <= 1'b0;
      res_paddr_q <= 36'h0_0000_0000;
      res_cca_q   <= 3'h0;
      res_seg_q   <= 3'h0;
    end
    else
    begin
      res_valid_q <= ref_valid_i;
      if (ref_valid_i)
      begin
        res_err_q   <= fin_err;
        res_map_q   <= fin_map;
        res_paddr_q <= (fin_err || fin_map) ? 36'h0_0000_0000 : fin_pa;
        res_cca_q   <= fin_cca;
        res_seg_q   <= seg_idx;
      end
    end
  end

  assign res_valid_o           = res_valid_q;
  assign res_addr_err_o        = res_err_q;
  assign res_mapped_o          = res_map_q;
  assign res_paddr_o           = res_paddr_q;
  assign res_cca_o             = res_cca_q;
  assign res_seg_o             = res_seg_q;
  assign walk_table_base_o     = walk_table_base_q;
  assign machine_check_cause_o = mc_cause_q;

  // Assertions
  a_user_err_mode0: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ref_valid_i && sel_am == 3'h0 && !err_unmap && priv == sac_pkg::PRIV_USER
      |=> res_valid_o && res_addr_err_o)
    else $error("Mode 000 user reference not errored");
  a_kern_map_mode1: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ref_valid_i && sel_am == 3'h1 && !err_unmap && priv == sac_pkg::PRIV_KERNEL
      |=> res_mapped_o && !res_addr_err_o)
    else $error("Mode 001 kernel reference not mapped");
  a_mode2_super: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ref_valid_i && sel_am == 3'h2 && !err_unmap && priv == sac_pkg::PRIV_SUPER
      |=> res_mapped_o)
    else $error("Mode 010 supervisor reference not mapped");
  a_mode4_kernel: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ref_valid_i && sel_am == 3'h4 && !err_unmap && priv == sac_pkg::PRIV_KERNEL
      |=> !res_mapped_o && !res_addr_err_o)
    else $error("Mode 100 kernel reference not unmapped");
  a_mode7_direct: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ref_valid_i && sel_am == 3'h7 |=> !res_mapped_o && !res_addr_err_o)
    else $error("Mode 111 reference not unmapped");
  a_mode6_error: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ref_valid_i && sel_am == 3'h6 && !err_unmap |=> res_addr_err_o)
    else $error("Mode 110 reference not errored");
  a_unmap_uncached: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ref_valid_i && err_unmap |=> !res_mapped_o && !res_addr_err_o && res_cca_o == 3'h2)
    else $error("Error-level unmap not applied");
  a_seg_top: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ref_valid_i && ref_vaddr_i[31:29] == 3'h7 |=> res_seg_o == 3'h0)
    else $error("Top segment not configuration zero");
  a_walk_store: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    wr_walk |=> walk_table_base_o == $past(reg_wdata_i))
    else $error("Walk base write not stored");
  a_cc_hold: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    wr_pair[0] && !CC_SUPPORTED[reg_wdata_i[2:0]] |=> $stable(cfg_q[0][2:0]))
    else $error("Unsupported coherency value stored");
  a_mc_hold: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    mc_event_i && mc_code_ok |=> machine_check_cause_o == $past(mc_code_i))
    else $error("Machine-check cause not captured");
  // More mode outcomes, error-level override excluded
  a_kern_unmap_mode0: assert property (
    ref_valid_i && sel_am == 3'h0 && !err_unmap && priv == sac_pkg::PRIV_KERNEL
      |=> !res_mapped_o && !res_addr_err_o)
    else $error("Mode 000 kernel reference not unmapped");
  a_super_err_mode1: assert property (
    ref_valid_i && sel_am == 3'h1 && !err_unmap && priv == sac_pkg::PRIV_SUPER
      |=> res_addr_err_o)
    else $error("Mode 001 supervisor reference not errored");
  a_user_err_mode2: assert property (
    ref_valid_i && sel_am == 3'h2 && !err_unmap && priv == sac_pkg::PRIV_USER
      |=> res_addr_err_o)
    else $error("Mode 010 user reference not errored");
  a_all_map_mode3: assert property (
    ref_valid_i && sel_am == 3'h3 && !err_unmap |=> res_mapped_o && !res_addr_err_o)
    else $error("Mode 011 reference not mapped");
  a_user_map_mode4: assert property (
    ref_valid_i && sel_am == 3'h4 && !err_unmap && priv == sac_pkg::PRIV_USER
      |=> res_mapped_o && !res_addr_err_o)
    else $error("Mode 100 user reference not mapped");
  a_super_unmap_mode5: assert property (
    ref_valid_i && sel_am == 3'h5 && !err_unmap && priv == sac_pkg::PRIV_SUPER
      |=> !res_mapped_o && !res_addr_err_o)
    else $error("Mode 101 supervisor reference not unmapped");
  a_user_err_mode5: assert property (
    ref_valid_i && sel_am == 3'h5 && !err_unmap && priv == sac_pkg::PRIV_USER
      |=> res_addr_err_o)
    else $error("Mode 101 user reference not errored");
  // Segment choice by address range
  a_seg_one: assert property (
    ref_valid_i && ref_vaddr_i[31:29] == 3'h6 |=> res_seg_o == 3'h1)
    else $error("Range 6 not configuration one");
  a_seg_two: assert property (
    ref_valid_i && ref_vaddr_i[31:29] == 3'h5 |=> res_seg_o == 3'h2)
    else $error("Range 5 not configuration two");
  a_seg_three: assert property (
    ref_valid_i && ref_vaddr_i[31:29] == 3'h4 |=> res_seg_o == 3'h3)
    else $error("Range 4 not configuration three");
  a_seg_four: assert property (
    ref_valid_i && ref_vaddr_i[31:30] == 2'h1 |=> res_seg_o == 3'h4)
    else $error("Upper user half not configuration four");
  a_seg_five: assert property (
    ref_valid_i && ref_vaddr_i[31:30] == 2'h0 |=> res_seg_o == 3'h5)
    else $error("Lower user half not configuration five");
  // Result fields
  a_unmap_pa_high: assert property (
    ref_valid_i && !fin_err && !fin_map |=> res_paddr_o[35:29] == $past(sel_pa))
    else $error("Unmapped physical high bits wrong");
  a_unmap_pa_low: assert property (
    ref_valid_i && !fin_err && !fin_map |=> res_paddr_o[28:0] == 29'($past(ref_vaddr_i)))
    else $error("Unmapped offset bits not passed through");
  a_mapped_no_pa: assert property (
    ref_valid_i && (fin_err || fin_map) |=> res_paddr_o == 36'h0_0000_0000)
    else $error("Physical address shown for a non-direct reference");
  a_cca_unmapped: assert property (
    ref_valid_i && !err_unmap |=> res_cca_o == 3'($past(sel_cfg)))
    else $error("Coherency not taken from configuration");
  a_res_valid_set: assert property (
    ref_valid_i |=> res_valid_o)
    else $error("Reference gave no result");
  a_res_valid_clr: assert property (
    !ref_valid_i |=> !res_valid_o)
    else $error("Result without a reference");
  // Register contents
  a_cfg_reserved: assert property (
    (rd_low & 32'h0180_0180) == 32'h0 && (rd_mid & 32'h0180_0180) == 32'h0
      && (rd_high & 32'h0180_0180) == 32'h0)
    else $error("Reserved configuration bits set");
  a_pair_write: assert property (
    wr_pair[1] |=> cfg_q[3][15:9] == 7'($past(reg_wdata_i) >> 25)
      && cfg_q[2][15:9] == 7'($past(reg_wdata_i) >> 9))
    else $error("Pair halves not stored in place");
  a_mode_write: assert property (
    wr_pair[2] |=> cfg_q[5][6:3] == 4'($past(reg_wdata_i) >> 19)
      && cfg_q[4][6:3] == 4'($past(reg_wdata_i) >> 3))
    else $error("Mode field not stored");
  a_cc_take: assert property (
    wr_pair[1] && CC_SUPPORTED[reg_wdata_i[18:16]]
      |=> cfg_q[3][2:0] == 3'($past(reg_wdata_i) >> 16))
    else $error("Supported coherency value not stored");
  a_cfg_hold: assert property (
    !reg_wr_i |=> $stable(rd_low) && $stable(rd_mid) && $stable(rd_high))
    else $error("Configuration changed without a write");
  // Reset state, walk base hold and the cause field
  a_reset_cfg: assert property (disable iff (1'b0)
    srst_i |=> cfg_q[0] == sac_pkg::CFG0_RST && cfg_q[1] == sac_pkg::CFG1_RST
      && cfg_q[2] == sac_pkg::CFG2_RST && cfg_q[3] == sac_pkg::CFG3_RST
      && cfg_q[4] == sac_pkg::CFG4_RST && cfg_q[5] == sac_pkg::CFG5_RST)
    else $error("Configuration reset value wrong");
  a_reset_walk: assert property (disable iff (1'b0)
    srst_i |=> walk_table_base_o == sac_pkg::WALK_RST)
    else $error("Walk base not cleared by reset");
  a_reset_cause: assert property (disable iff (1'b0)
    srst_i |=> machine_check_cause_o == sac_pkg::MC_NONE)
    else $error("Cause not cleared by reset");
  a_walk_hold: assert property (
    !wr_walk |=> $stable(walk_table_base_o))
    else $error("Walk base changed without a write");
  a_mc_clear: assert property (
    mc_clear_i && !(mc_event_i && mc_code_ok) |=> machine_check_cause_o == sac_pkg::MC_NONE)
    else $error("Cause not cleared");
  a_mc_ignore: assert property (
    mc_event_i && !mc_code_ok && !mc_clear_i |=> $stable(machine_check_cause_o))
    else $error("Reserved cause code reached the field");
  a_mc_fixed: assert property (
    mc_event_i && (mc_code_i == sac_pkg::MC_FIX_SIZE || mc_code_i == sac_pkg::MC_FIX_SET)
      |=> machine_check_cause_o == $past(mc_code_i))
    else $error("Fixed-page cause not captured");
endmodule
